// ---- src/pti_defines.svh ----
`ifndef PTI_DEFINES_SVH
`define PTI_DEFINES_SVH
// Contract
// - Every register and control flop takes a defined default at reset.
// - Separate 16-bit low and high thresholds compared against each result.
// - Interrupt only after persistence-count plus one consecutive results beyond the active threshold.
// - Force mode: no new result until trigger written; one result each.
// - Result is raw measurement minus the 16-bit cancel value.
// - Enabled interrupt condition drives the interrupt pin low.
// - Controls stay usable while the interrupt pin is asserted.
// - Trigger-type field selects which events raise an interrupt.
// - Any flag bit going from zero to one pulls the pin low; in logic output mode the code drives the pin from presence only.
// - Reading flags returns them, then clears them and releases the pin; in logic output mode the pin stays with presence.
// - Logic output mode: pin low while object near, high when away.
// - Approach uses the high threshold, away uses the low threshold.
// - Normal mode: pending flags block further events until read.
// - Flag bit 1 approach, bit 0 away, bit 6 protection entry.
// - Trigger type: 00 off, 01 approach, 10 away, 11 both.
// - Persistence codes 00..11 need 1..4 consecutive results.
// - One-shot trigger bit returns to zero after its single measurement.
`define PTI_FLAG_AWAY 0
`define PTI_FLAG_APPROACH 1
`define PTI_FLAG_PROTECT 6
`define PTI_FLAG_RESET 8'h00
`define PTI_TRIG_OFF 2'h0
`define PTI_TRIG_APPROACH 2'h1
`define PTI_TRIG_AWAY 2'h2
`define PTI_TRIG_BOTH 2'h3
`define PTI_DATA_RESET 16'h0000
`endif

// ---- src/pti_pkg.sv ----
package pti_pkg;
    typedef enum logic [1:0] {
        PTI_FAR = 2'h1,
        PTI_NEAR = 2'h2
    } pti_prox_t;
endpackage

// ---- src/pti_top.sv ----
`timescale 1ns/1ps
`include "pti_defines.svh"
module pti_top import pti_pkg::*; #(
    parameter int DATA_W = 16
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic raw_valid,
    input wire logic [DATA_W-1:0] raw_data,
    input wire logic force_mode_enable,
    input wire logic one_shot_write,
    input wire logic [1:0] trigger_type_select,
    input wire logic logic_output_select,
    input wire logic [1:0] persistence_count,
    input wire logic [DATA_W-1:0] crosstalk_cancel_value,
    input wire logic [DATA_W-1:0] low_threshold,
    input wire logic [DATA_W-1:0] high_threshold,
    input wire logic protection_event,
    input wire logic flag_read,
    output logic int_n,
    output logic [7:0] flag_rdata,
    output logic [DATA_W-1:0] result,
    output logic result_valid,
    output logic one_shot_trigger,
    output logic measure_enable
);

    // ----------------------------------------
    // Reset synchronisers
    // ----------------------------------------
    logic rst_a, rst_b, lrst_a, lrst_b;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_a <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_a <= 1'b1;
            rst_b <= rst_a;
        end
    end
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_a <= 1'b0;
            lrst_b <= 1'b0;
        end else begin
            lrst_a <= 1'b1;
            lrst_b <= lrst_a;
        end
    end

    // ----------------------------------------
    // Link side: sample capture and handshake
    // ----------------------------------------
    // Samples arriving while a word is in flight are dropped; the
    // front end is far slower than the round trip.
    logic en_s1, en_s2, ack_s1, ack_s2, lreq;
    logic [DATA_W-1:0] lhold;
    logic ack;
    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            en_s1 <= measure_enable;
            en_s2 <= en_s1;
            ack_s1 <= ack;
            ack_s2 <= ack_s1;
        end
    end
    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            lreq <= 1'b0;
            lhold <= `PTI_DATA_RESET;
        end else if (raw_valid && en_s2 && (lreq == ack_s2)) begin
            lhold <= raw_data;
            lreq <= ~lreq;
        end
    end

    // ----------------------------------------
    // Core side: sample arrival
    // ----------------------------------------
    logic req_s1, req_s2, req_s3;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            ack <= 1'b0;
        end else begin
            req_s1 <= lreq;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            ack <= req_s2;
        end
    end
    logic arrive, take;
    assign arrive = req_s2 ^ req_s3;
    // Late samples in force mode without a trigger are discarded
    assign take = arrive && (!force_mode_enable || one_shot_trigger);

    // ----------------------------------------
    // Force mode trigger
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            one_shot_trigger <= 1'b0;
        end else if (one_shot_write && force_mode_enable) begin
            one_shot_trigger <= 1'b1;
        end else if (take) begin
            one_shot_trigger <= 1'b0;
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            measure_enable <= 1'b0;
        end else begin
            measure_enable <= !force_mode_enable || one_shot_trigger;
        end
    end

    // ----------------------------------------
    // Cancellation and result
    // ----------------------------------------
    // Saturate at zero rather than wrap to a huge proximity value
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            result <= `PTI_DATA_RESET;
            result_valid <= 1'b0;
        end else begin
            result_valid <= take;
            if (take) begin
                result <= (lhold > crosstalk_cancel_value) ? lhold - crosstalk_cancel_value
                                                           : `PTI_DATA_RESET;
            end
        end
    end

    // ----------------------------------------
    // Threshold, persistence, hysteresis
    // ----------------------------------------
    pti_prox_t prox;
    logic [1:0] run;
    logic above, below, cond, blocked, hit;
    logic [7:0] flags;
    assign above = result > high_threshold;
    assign below = result < low_threshold;
    assign cond = (prox == PTI_FAR) ? above : below;
    assign blocked = !logic_output_select && (flags != `PTI_FLAG_RESET);
    assign hit = result_valid && !blocked && cond && (run == persistence_count);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            run <= 2'h0;
        end else if (result_valid) begin
            if (!cond || blocked || hit) begin
                run <= 2'h0;
            end else begin
                run <= run + 2'h1;
            end
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prox <= PTI_FAR;
        end else if (hit) begin
            prox <= (prox == PTI_FAR) ? PTI_NEAR : PTI_FAR;
        end
    end

    // ----------------------------------------
    // Flags and read-clear
    // ----------------------------------------
    logic set_app, set_away;
    logic [7:0] flag_set;
    assign set_app = hit && prox == PTI_FAR && !logic_output_select && trigger_type_select[0];
    assign set_away = hit && prox == PTI_NEAR && !logic_output_select && trigger_type_select[1];
    always_comb begin
        flag_set = `PTI_FLAG_RESET;
        flag_set[`PTI_FLAG_APPROACH] = set_app;
        flag_set[`PTI_FLAG_AWAY] = set_away;
        flag_set[`PTI_FLAG_PROTECT] = protection_event;
    end
    // A set in the read cycle survives the clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= `PTI_FLAG_RESET;
        end else if (flag_read) begin
            flags <= flag_set;
        end else begin
            flags <= flags | flag_set;
        end
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_rdata <= `PTI_FLAG_RESET;
        end else if (flag_read) begin
            flag_rdata <= flags;
        end
    end

    // ----------------------------------------
    // Interrupt pin
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_n <= 1'b1;
        end else if (logic_output_select) begin
            int_n <= (prox != PTI_NEAR);
        end else begin
            int_n <= (flags == `PTI_FLAG_RESET);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_cancel_sub: assert property (take |=> result == (($past(lhold) > $past(crosstalk_cancel_value)) ?
        $past(lhold) - $past(crosstalk_cancel_value) : 16'h0000))
        else $error("result not raw minus cancel");
    a_force_hold: assert property (force_mode_enable && !one_shot_trigger |=> !result_valid)
        else $error("result in force mode without trigger");
    a_trig_self_clear: assert property (one_shot_trigger && take && !one_shot_write |=> !one_shot_trigger)
        else $error("trigger bit did not return to zero");
    a_approach_flag: assert property (set_app && !flag_read |=> flags[1] ##1 !int_n)
        else $error("approach flag or pin missing");
    a_read_clear: assert property (flag_read && !logic_output_select && flag_set == 8'h00
        |=> flags == 8'h00 ##1 int_n)
        else $error("flags not cleared by read");
    a_read_data: assert property (flag_read |=> flag_rdata == $past(flags))
        else $error("read data not old flags");
    a_block_pending: assert property (blocked && !flag_read && !protection_event |=> $stable(flags))
        else $error("event taken while flags pending");
    a_persist_run: assert property (result_valid && cond && !blocked && run != persistence_count
        |=> $stable(prox))
        else $error("trigger before persistence run");
    a_run_restart: assert property (result_valid && !cond |=> run == 2'h0)
        else $error("run not restarted");
    a_logic_pin: assert property (logic_output_select && $past(logic_output_select)
        |-> int_n == ($past(prox) != PTI_NEAR))
        else $error("logic output pin wrong");
    a_type_off: assert property (trigger_type_select == 2'h0 && !flag_read |=> $stable(flags[1:0]))
        else $error("flag set with interrupts off");
    a_enable_force: assert property (force_mode_enable && !one_shot_trigger |=> !measure_enable)
        else $error("front end enabled in force mode without trigger");
    a_enable_normal: assert property (!force_mode_enable |=> measure_enable)
        else $error("front end idle in continuous mode");
    a_trig_set: assert property (one_shot_write && force_mode_enable |=> one_shot_trigger)
        else $error("trigger write not taken");
    a_trig_ignored: assert property (!force_mode_enable && !one_shot_trigger |=> !one_shot_trigger)
        else $error("trigger set outside force mode");
    a_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("result valid longer than one cycle");
    a_result_hold: assert property (!take |=> $stable(result))
        else $error("result changed without a sample");
    a_pin_flags: assert property (!logic_output_select && flags != 8'h00 |=> !int_n)
        else $error("pin high with flags pending");
    a_pin_idle: assert property (!logic_output_select && flags == 8'h00 |=> int_n)
        else $error("pin low with no flags");
    a_away_flag: assert property (set_away |=> flags[`PTI_FLAG_AWAY])
        else $error("away flag missing");
    a_protect_flag: assert property (protection_event |=> flags[`PTI_FLAG_PROTECT])
        else $error("protection flag missing");
    a_logic_no_flag: assert property (logic_output_select && !protection_event && !flag_read
        |=> $stable(flags))
        else $error("flag set in logic output mode");
    a_prox_hold: assert property (!result_valid || !cond |=> $stable(prox))
        else $error("presence state moved without a qualifying result");
    a_run_frozen: assert property (blocked && result_valid |=> run == 2'h0)
        else $error("run counted while flags pending");
    a_rdata_hold: assert property (!flag_read |=> $stable(flag_rdata))
        else $error("read data changed without a read");

    c_approach: cover property (set_app);
    c_away: cover property (set_away);
    c_oneshot: cover property (one_shot_trigger && take);
    c_read_set: cover property (flag_read && flag_set != 8'h00);
    c_blocked: cover property (blocked && result_valid && cond);

    // ----------------------------------------
    // Link-side checks
    // ----------------------------------------
    // Round-trip age; a stuck crossing would starve the front end silently
    logic [3:0] flight;
    always_ff @(posedge link_clk or negedge lrst_b) begin
        if (!lrst_b) begin
            flight <= 4'h0;
        end else if (lreq == ack_s2) begin
            flight <= 4'h0;
        end else if (flight != 4'hF) begin
            flight <= flight + 4'h1;
        end
    end
    a_link_hold: assert property (@(posedge link_clk) disable iff (!lrst_b)
        lreq != ack_s2 |=> $stable(lhold))
        else $error("held sample changed in flight");
    a_link_drop: assert property (@(posedge link_clk) disable iff (!lrst_b)
        !en_s2 |=> $stable(lreq))
        else $error("sample taken while front end disabled");
    a_flight_bound: assert property (@(posedge link_clk) disable iff (!lrst_b)
        flight <= 4'h8)
        else $error("sample round trip too long");

endmodule

// ---- dv/pti_front_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Front-end sample source
// ----------------------------------------
module pti_front_model (
    input wire logic link_clk,
    input wire logic measure_enable,
    output logic raw_valid,
    output logic [15:0] raw_data
);
    initial begin
        raw_valid = 1'b0;
        raw_data = 16'h0000;
    end
    // Bounded wait, then send anyway so dropped samples can be tested
    task automatic send(input logic [15:0] v);
        int i;
        i = 0;
        while (measure_enable !== 1'b1 && i < 8) begin
            @(posedge link_clk);
            i++;
        end
        // Let the enable cross the two link flops before sampling
        repeat (2) @(posedge link_clk);
        @(posedge link_clk);
        #1;
        raw_valid = 1'b1;
        raw_data = v;
        @(posedge link_clk);
        #1;
        raw_valid = 1'b0;
        // Stale data inverted, never left looking valid
        raw_data = ~v;
    endtask
endmodule

// ---- dv/proximity_threshold_interrupt_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module proximity_threshold_interrupt_tb;
    logic core_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, force_mode_enable = 1'b0;
    logic one_shot_write = 1'b0, logic_output_select = 1'b0, protection_event = 1'b0;
    logic flag_read = 1'b0, raw_valid, int_n, result_valid, one_shot_trigger, measure_enable;
    logic [1:0] trigger_type_select = 2'h0, persistence_count = 2'h0;
    logic [15:0] crosstalk_cancel_value = 16'h0000, raw_data, result;
    logic [15:0] low_threshold = 16'h0080, high_threshold = 16'h0200;
    logic [7:0] flag_rdata;
    int bad_count = 0, checked = 0;
    always #20 core_clk = ~core_clk;
    always #24 link_clk = ~link_clk;
    pti_top dut (.core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .raw_valid(raw_valid),
        .raw_data(raw_data), .force_mode_enable(force_mode_enable), .one_shot_write(one_shot_write),
        .trigger_type_select(trigger_type_select), .logic_output_select(logic_output_select),
        .persistence_count(persistence_count), .crosstalk_cancel_value(crosstalk_cancel_value),
        .low_threshold(low_threshold), .high_threshold(high_threshold),
        .protection_event(protection_event), .flag_read(flag_read), .int_n(int_n),
        .flag_rdata(flag_rdata), .result(result), .result_valid(result_valid),
        .one_shot_trigger(one_shot_trigger), .measure_enable(measure_enable));
    pti_front_model model (.link_clk(link_clk), .measure_enable(measure_enable),
        .raw_valid(raw_valid), .raw_data(raw_data));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic read_flags(input logic [7:0] e);
        step(1);
        flag_read = 1'b1;
        step(1);
        flag_read = 1'b0;
        step(1);
        `CHK("flag_rdata", e, flag_rdata)
        `CHK("int_n", 1'b1, int_n)
    endtask
    // Result pulse sampled mid-cycle, away from the launching edge
    task automatic meas(input logic [15:0] v, input logic ev, input logic [15:0] er);
        int i;
        logic seen;
        seen = 1'b0;
        i = 0;
        model.send(v);
        while (!seen && i < 40) begin
            @(negedge core_clk);
            seen = (result_valid === 1'b1);
            i++;
        end
        `CHK("result_valid", ev, seen)
        if (ev) `CHK("result", er, result)
        step(6);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        logic [15:0] v;
        step(10);
        rst_n = 1'b1;
        step(5);
        `CHK("int_n", 1'b1, int_n)
        `CHK("flag_rdata", 8'h00, flag_rdata)
        `CHK("one_shot_trigger", 1'b0, one_shot_trigger)
        `CHK("measure_enable", 1'b1, measure_enable)
        $display("test reset done");
        crosstalk_cancel_value = 16'h0010;
        meas(16'h0300, 1'b1, 16'h02F0);
        `CHK("int_n", 1'b1, int_n)
        read_flags(8'h00);
        trigger_type_select = 2'h2;
        meas(16'h0050, 1'b1, 16'h0040);
        `CHK("int_n", 1'b0, int_n)
        read_flags(8'h01);
        $display("test cancel and trigger type done");
        crosstalk_cancel_value = 16'h0000;
        trigger_type_select = 2'h1;
        persistence_count = 2'h2;
        // Third sample breaks the run, so only the last three count
        for (int k = 0; k < 6; k++) begin
            v = (k == 2) ? 16'h0100 : 16'h0300;
            meas(v, 1'b1, v);
            `CHK("int_n", (k < 5), int_n)
        end
        trigger_type_select = 2'h3;
        persistence_count = 2'h0;
        meas(16'h0010, 1'b1, 16'h0010);
        read_flags(8'h02);
        meas(16'h0010, 1'b1, 16'h0010);
        `CHK("int_n", 1'b0, int_n)
        read_flags(8'h01);
        $display("test persistence and pending done");
        logic_output_select = 1'b1;
        meas(16'h0300, 1'b1, 16'h0300);
        `CHK("int_n", 1'b0, int_n)
        meas(16'h0010, 1'b1, 16'h0010);
        `CHK("int_n", 1'b1, int_n)
        logic_output_select = 1'b0;
        read_flags(8'h00);
        step(1);
        protection_event = 1'b1;
        step(1);
        protection_event = 1'b0;
        step(3);
        `CHK("int_n", 1'b0, int_n)
        read_flags(8'h40);
        $display("test logic mode and protection done");
        force_mode_enable = 1'b1;
        step(4);
        `CHK("measure_enable", 1'b0, measure_enable)
        meas(16'h0123, 1'b0, 16'h0000);
        one_shot_write = 1'b1;
        step(1);
        one_shot_write = 1'b0;
        step(2);
        `CHK("one_shot_trigger", 1'b1, one_shot_trigger)
        meas(16'h0123, 1'b1, 16'h0123);
        `CHK("one_shot_trigger", 1'b0, one_shot_trigger)
        `CHK("measure_enable", 1'b0, measure_enable)
        $display("test force mode done");
        report_and_stop();
    end
    // Tests need well under 100 us; generous margin
    initial begin
        #400000;
        bad_count++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule
